//--- shared/ucp_pkg.sv
package ucp_pkg;

  // register byte addresses on the bus, one aligned word each
  localparam logic [7:0] ADDR_BAUD_HIGH = 8'h00;
  localparam logic [7:0] ADDR_BAUD_LOW  = 8'h04;
  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h08;
  localparam logic [7:0] ADDR_CTRL_TWO  = 8'h0c;
  localparam logic [7:0] ADDR_STAT_ONE  = 8'h10;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h14;
  localparam logic [7:0] ADDR_DATA_LOW  = 8'h18;

  // control_reg_one field positions
  localparam int unsigned CR1_CHAR9_BIT   = 4;
  localparam int unsigned CR1_PAR_EN_BIT  = 1;
  localparam int unsigned CR1_PAR_ODD_BIT = 0;
  localparam logic [7:0]  CR1_MASK        = 8'h13;

  // control_reg_two field positions
  localparam int unsigned CR2_TXE_IRQ_BIT = 7;
  localparam int unsigned CR2_RXF_IRQ_BIT = 5;
  localparam int unsigned CR2_TX_EN_BIT   = 3;
  localparam int unsigned CR2_RX_ON_BIT   = 2;
  localparam int unsigned CR2_BREAK_BIT   = 0;
  localparam logic [7:0]  CR2_MASK        = 8'had;

  // status_reg_one and data_reg_high field positions
  localparam int unsigned SR1_TX_BUFFER_EMPTY_BIT = 7;
  localparam int unsigned SR1_TC_BIT   = 6;
  localparam int unsigned SR1_RX_BUFFER_FULL_BIT = 5;
  localparam int unsigned SR1_FE_BIT   = 1;
  localparam int unsigned DRH_RX9_BIT  = 7;
  localparam int unsigned DRH_TX9_BIT  = 6;

  // reset values
  localparam logic [12:0] BAUD_RESET = 13'h0000;
  localparam logic [7:0]  CR1_RESET  = 8'h00;
  localparam logic [7:0]  CR2_RESET  = 8'h00;
  localparam logic        TX_BUFFER_EMPTY_RESET = 1'b1;

  // bit timing in receiver clock ticks (16 per bit)
  localparam logic [3:0] RT_LAST_PHASE   = 4'hf;
  localparam logic [3:0] TX_LOAD_TICKS   = 4'h9;
  localparam logic [3:0] TX_LOAD_PHASE   = TX_LOAD_TICKS - 4'h1;
  localparam logic [3:0] RX_SAMPLE_PHASE = 4'h7;

  // character lengths in bits
  localparam logic [3:0] LEN_8       = 4'ha;
  localparam logic [3:0] LEN_9       = 4'hb;
  localparam logic [3:0] BRK_TAIL    = 4'h1;
  localparam logic [3:0] RX_STOP_8   = 4'h9;
  localparam logic [3:0] RX_STOP_9   = 4'ha;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [4:0]  baud_hi_pend;
    logic [12:0] divisor;
    logic [12:0] baud_cnt;
    logic [7:0]  cr1;
    logic [7:0]  cr2;
    logic [7:0]  tx_buf;
    logic        tx_ninth_bit;
    logic        tx_buffer_empty;
    logic        tx_buffer_empty_armed;
    logic [10:0] tx_sr;
    logic [3:0]  tx_left;
    logic [3:0]  tx_phase;
    logic [10:0] pend_sr;
    logic [3:0]  pend_len;
    logic        pend_valid;
    logic        preamble_req;
    logic        after_break;
    logic        tx_out;
    logic        tx_oe;
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_prev;
    logic        rx_busy;
    logic [3:0]  rx_phase;
    logic [3:0]  rx_bit;
    logic [9:0]  rx_sh;
    logic [7:0]  rx_data;
    logic        rx_ninth_bit;
    logic        rx_buffer_full;
    logic        framing_fault;
    logic        rx_buffer_full_armed;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
  } ucp_state_type;

endpackage

//--- src/ucp_uart_path.sv
// Operation
// RQ1: nine-bit mode sends tx_ninth_bit as data bit 8.
// RQ2: buffered data enters shift register, framed by start and stop bits.
// RQ3: every buffer to shift register move sets tx_buffer_empty.
// RQ4: next character moves in nine-sixteenths into the previous stop bit.
// RQ5: tx_buffer_empty reads one after reset.
// RQ6: a written character waits until tx_buffer_empty is cleared.
// RQ7: tx_enable rising loads preamble of 10 or 11 ones first.
// RQ8: start bit zero at shift register lsb, stop bit one at msb.
// RQ9: odd or even parity replaces the character's most significant bit.
// RQ10: tx_buffer_empty with its enable raises the transmit interrupt.
// RQ11: line idles high; clearing tx_enable lets current frame finish.
// RQ12: tx_enable off then on during a frame queues one idle character.
// RQ13: software restores tx_enable before the current stop bit leaves.
// RQ14: send_break keeps loading all-zero characters of character length.
// RQ15: after send_break clears, finish break then send at least one one.
// RQ16: idle characters are all ones of character length.
// RQ17: received break sets framing_fault and rx_buffer_full, clears data.
// RQ18: transmit pin released when disabled and nothing in progress.
// RQ19: complete received frame moves to data register, sets rx_buffer_full.
// RQ20: rx_buffer_full with its enable raises the receive interrupt.
// RQ21: nine-bit mode stores received bit 8 in rx_ninth_bit.
// RQ22: divisor takes effect on low byte write; zero stops the generator.
// RQ23: 13-bit modulus counter gives 16x clock; divided by 16 for transmit.
// RQ24: status read with flag set, then data write, clears tx_buffer_empty.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ucp_uart_path
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             tx_out,
  output logic             tx_oe,
  input  wire logic        rx_in,
  output logic             tx_irq,
  output logic             rx_irq
);

  typedef enum {
    REG_BAUD_HIGH,
    REG_BAUD_LOW,
    REG_CTRL_ONE,
    REG_CTRL_TWO,
    REG_STAT_ONE,
    REG_DATA_HIGH,
    REG_DATA_LOW,
    REG_NONE
  } ucp_reg_type;

  ucp_pkg::ucp_state_type s_r;
  ucp_pkg::ucp_state_type s_nxt;

  logic        rt_tick;
  logic        char9;
  logic        ld_go;
  logic [10:0] ld_sr;
  logic [3:0]  ld_len;
  logic        ld_is_data;
  logic        ld_point;
  logic [9:0]  rx_fin;
  logic [3:0]  rx_stop_idx;
  logic        tx_done;
  ucp_reg_type rd_reg;
  ucp_reg_type wr_reg;

  // address decode shared by the read and write paths
  function automatic ucp_reg_type decode(input logic [7:0] addr);
    case (addr)
      ucp_pkg::ADDR_BAUD_HIGH: decode = REG_BAUD_HIGH;
      ucp_pkg::ADDR_BAUD_LOW:  decode = REG_BAUD_LOW;
      ucp_pkg::ADDR_CTRL_ONE:  decode = REG_CTRL_ONE;
      ucp_pkg::ADDR_CTRL_TWO:  decode = REG_CTRL_TWO;
      ucp_pkg::ADDR_STAT_ONE:  decode = REG_STAT_ONE;
      ucp_pkg::ADDR_DATA_HIGH: decode = REG_DATA_HIGH;
      ucp_pkg::ADDR_DATA_LOW:  decode = REG_DATA_LOW;
      default:                 decode = REG_NONE;
    endcase
  endfunction

  // data frame: start at lsb, stop at msb, parity over the data bits
  function automatic logic [10:0] build_frame
  (
    input logic [7:0] d,
    input logic       t8,
    input logic       nine,
    input logic       par_en,
    input logic       par_odd
  );
    logic [7:0] dd;
    logic       b8;
    dd = d;
    b8 = t8;
    if (nine)
    begin
      if (par_en)
      begin
        b8 = (^d) ^ par_odd; // RQ9
      end
      build_frame = {1'b1, b8, dd, 1'b0}; // RQ1 RQ8
    end
    else
    begin
      if (par_en)
      begin
        dd[7] = (^d[6:0]) ^ par_odd; // RQ9
      end
      build_frame = {2'b11, dd, 1'b0}; // RQ8
    end
  endfunction

  // status byte, built from live flags
  function automatic logic [7:0] stat_byte(input ucp_pkg::ucp_state_type st, input logic done);
    logic [7:0] v;
    v = 8'h00;
    v[ucp_pkg::SR1_TX_BUFFER_EMPTY_BIT] = st.tx_buffer_empty;
    v[ucp_pkg::SR1_TC_BIT]   = done;
    v[ucp_pkg::SR1_RX_BUFFER_FULL_BIT] = st.rx_buffer_full;
    v[ucp_pkg::SR1_FE_BIT]   = st.framing_fault;
    stat_byte = v;
  endfunction

  // handshake outputs straight from the state
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = {24'h00_0000, s_r.rdata};
  assign tx_out        = s_r.tx_out;
  assign tx_oe         = s_r.tx_oe;
  // interrupt requests are plain flag-and-enable terms
  assign tx_irq = s_r.tx_buffer_empty && s_r.cr2[ucp_pkg::CR2_TXE_IRQ_BIT]; // RQ10
  assign rx_irq = s_r.rx_buffer_full && s_r.cr2[ucp_pkg::CR2_RXF_IRQ_BIT]; // RQ20

  // whole next-state computation; software effects first so hardware sets win
  always_comb
  begin
    s_nxt       = s_r;
    char9       = s_r.cr1[ucp_pkg::CR1_CHAR9_BIT];
    tx_done     = (s_r.tx_left == 4'h0) && !s_r.pend_valid;
    rd_reg      = decode(s_axi_araddr);
    wr_reg      = decode(s_r.aw_addr);
    rt_tick     = 1'b0;
    ld_go       = 1'b0;
    ld_sr       = 11'h7ff;
    ld_len      = 4'h0;
    ld_is_data  = 1'b0;
    ld_point    = 1'b0;
    rx_fin      = {s_r.rx_s2, s_r.rx_sh[9:1]};
    rx_stop_idx = char9 ? ucp_pkg::RX_STOP_9 : ucp_pkg::RX_STOP_8;

    // write channel capture, address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_got   = 1'b1;
      s_nxt.w_data  = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end

    // perform the write once both halves are held
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = (wr_reg == REG_NONE) ? ucp_pkg::RESP_SLVERR : ucp_pkg::RESP_OKAY;
      if (s_r.w_lane0)
      begin
        case (wr_reg)
          REG_BAUD_HIGH: s_nxt.baud_hi_pend = s_r.w_data[4:0]; // RQ22
          REG_BAUD_LOW:
          begin
            s_nxt.divisor  = {s_r.baud_hi_pend, s_r.w_data}; // RQ22
            s_nxt.baud_cnt = 13'h0000;
          end
          REG_CTRL_ONE:  s_nxt.cr1 = s_r.w_data & ucp_pkg::CR1_MASK;
          REG_CTRL_TWO:
          begin
            s_nxt.cr2 = s_r.w_data & ucp_pkg::CR2_MASK;
            // a rising enable queues a preamble, also mid-frame
            if (s_r.w_data[ucp_pkg::CR2_TX_EN_BIT] && !s_r.cr2[ucp_pkg::CR2_TX_EN_BIT])
            begin
              s_nxt.preamble_req = 1'b1; // RQ7 RQ12
            end
          end
          REG_DATA_HIGH: s_nxt.tx_ninth_bit = s_r.w_data[ucp_pkg::DRH_TX9_BIT];
          REG_DATA_LOW:
          begin
            s_nxt.tx_buf = s_r.w_data;
            if (s_r.tx_buffer_empty_armed)
            begin
              s_nxt.tx_buffer_empty = 1'b0; // RQ24
              s_nxt.tx_buffer_empty_armed      = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    // read channel: answer one cycle after the address is taken
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = (rd_reg == REG_NONE) ? ucp_pkg::RESP_SLVERR : ucp_pkg::RESP_OKAY;
      case (rd_reg)
        REG_BAUD_HIGH: s_nxt.rdata = {3'h0, s_r.divisor[12:8]};
        REG_BAUD_LOW:  s_nxt.rdata = s_r.divisor[7:0];
        REG_CTRL_ONE:  s_nxt.rdata = s_r.cr1;
        REG_CTRL_TWO:  s_nxt.rdata = s_r.cr2;
        REG_STAT_ONE:
        begin
          s_nxt.rdata = stat_byte(s_r, tx_done);
          // arming only counts while the flag is seen set
          if (s_r.tx_buffer_empty)
          begin
            s_nxt.tx_buffer_empty_armed = 1'b1; // RQ24
          end
          if (s_r.rx_buffer_full)
          begin
            s_nxt.rx_buffer_full_armed = 1'b1;
          end
        end
        REG_DATA_HIGH: s_nxt.rdata = {s_r.rx_ninth_bit, s_r.tx_ninth_bit, 6'h00};
        REG_DATA_LOW:
        begin
          s_nxt.rdata = s_r.rx_data;
          if (s_r.rx_buffer_full_armed)
          begin
            s_nxt.rx_buffer_full = 1'b0;
            s_nxt.rx_buffer_full_armed     = 1'b0;
          end
        end
        default:       s_nxt.rdata = 8'h00;
      endcase
    end

    // modulus counter; zero divisor holds the generator still
    if (s_r.divisor != 13'h0000)
    begin
      if (s_r.baud_cnt >= s_r.divisor - 13'h0001)
      begin
        s_nxt.baud_cnt = 13'h0000;
        rt_tick        = 1'b1; // RQ23
      end
      else
      begin
        s_nxt.baud_cnt = s_r.baud_cnt + 13'h0001;
      end
    end // RQ22

    // load choice: preamble, then break, then break tail, then data
    if (s_r.cr2[ucp_pkg::CR2_TX_EN_BIT])
    begin
      if (s_r.preamble_req)
      begin
        ld_go  = 1'b1;
        ld_sr  = 11'h7ff; // RQ16
        ld_len = char9 ? ucp_pkg::LEN_9 : ucp_pkg::LEN_8; // RQ7
      end
      else if (s_r.cr2[ucp_pkg::CR2_BREAK_BIT])
      begin
        ld_go  = 1'b1;
        ld_sr  = 11'h000;
        ld_len = char9 ? ucp_pkg::LEN_9 : ucp_pkg::LEN_8; // RQ14
      end
      else if (s_r.after_break)
      begin
        ld_go  = 1'b1;
        ld_sr  = 11'h7ff;
        ld_len = ucp_pkg::BRK_TAIL; // RQ15
      end
      else if (!s_r.tx_buffer_empty)
      begin
        ld_go      = 1'b1; // RQ6
        ld_is_data = 1'b1;
        ld_sr      = build_frame(s_r.tx_buf, s_r.tx_ninth_bit, char9,
                                 s_r.cr1[ucp_pkg::CR1_PAR_EN_BIT],
                                 s_r.cr1[ucp_pkg::CR1_PAR_ODD_BIT]); // RQ2
        ld_len     = char9 ? ucp_pkg::LEN_9 : ucp_pkg::LEN_8;
      end
    end

    // transmitter: one bit per 16 ticks, lsb first
    if (rt_tick)
    begin
      ld_point = ((s_r.tx_left == 4'h1) && (s_r.tx_phase == ucp_pkg::TX_LOAD_PHASE)
                  && !s_r.pend_valid) || tx_done; // RQ4
      if (s_r.tx_left != 4'h0)
      begin
        if (s_r.tx_phase == ucp_pkg::RT_LAST_PHASE)
        begin
          s_nxt.tx_phase = 4'h0;
          s_nxt.tx_sr    = {1'b1, s_r.tx_sr[10:1]};
          s_nxt.tx_left  = s_r.tx_left - 4'h1;
          // the staged character follows the stop bit with no gap
          if ((s_r.tx_left == 4'h1) && s_r.pend_valid)
          begin
            s_nxt.tx_sr      = s_r.pend_sr;
            s_nxt.tx_left    = s_r.pend_len;
            s_nxt.pend_valid = 1'b0;
          end
        end
        else
        begin
          s_nxt.tx_phase = s_r.tx_phase + 4'h1;
        end
      end
      if (ld_point && ld_go)
      begin
        if (tx_done)
        begin
          s_nxt.tx_sr    = ld_sr;
          s_nxt.tx_left  = ld_len;
          s_nxt.tx_phase = 4'h0;
        end
        else
        begin
          s_nxt.pend_sr    = ld_sr;
          s_nxt.pend_len   = ld_len;
          s_nxt.pend_valid = 1'b1;
        end
        if (s_r.preamble_req)
        begin
          s_nxt.preamble_req = 1'b0;
        end
        else if (s_r.cr2[ucp_pkg::CR2_BREAK_BIT])
        begin
          s_nxt.after_break = 1'b1; // RQ15
        end
        else if (s_r.after_break)
        begin
          s_nxt.after_break = 1'b0;
        end
        if (ld_is_data)
        begin
          s_nxt.tx_buffer_empty = 1'b1; // RQ3
          s_nxt.tx_buffer_empty_armed      = 1'b0;
        end
      end
    end

    // line level follows the shift register; pin owned while shifting, staged or enabled
    s_nxt.tx_out = (s_nxt.tx_left != 4'h0) ? s_nxt.tx_sr[0] : 1'b1; // RQ11
    s_nxt.tx_oe  = (s_nxt.tx_left != 4'h0) || s_nxt.pend_valid
                   || s_nxt.cr2[ucp_pkg::CR2_TX_EN_BIT]; // RQ18

    // rx pin through two flops; the first feeds only the second
    s_nxt.rx_s1   = rx_in;
    s_nxt.rx_s2   = s_r.rx_s1;
    s_nxt.rx_prev = s_r.rx_s2;

    // receiver: simple mid-bit sampling, no majority vote
    if (rt_tick)
    begin
      if (!s_r.rx_busy)
      begin
        if (s_r.cr2[ucp_pkg::CR2_RX_ON_BIT] && s_r.rx_prev && !s_r.rx_s2)
        begin
          s_nxt.rx_busy  = 1'b1;
          s_nxt.rx_phase = 4'h0;
          s_nxt.rx_bit   = 4'h0;
        end
      end
      else
      begin
        s_nxt.rx_phase = s_r.rx_phase + 4'h1;
        if (s_r.rx_phase == ucp_pkg::RX_SAMPLE_PHASE)
        begin
          if (s_r.rx_bit == 4'h0)
          begin
            // a high start sample was a glitch: drop back to search
            s_nxt.rx_busy = !s_r.rx_s2;
            s_nxt.rx_bit  = 4'h1;
          end
          else
          begin
            s_nxt.rx_sh  = rx_fin;
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
            if (s_r.rx_bit == rx_stop_idx)
            begin
              s_nxt.rx_busy        = 1'b0;
              s_nxt.rx_data        = char9 ? rx_fin[7:0] : rx_fin[8:1]; // RQ19
              s_nxt.rx_ninth_bit   = char9 ? rx_fin[8] : 1'b0; // RQ21
              s_nxt.framing_fault  = !rx_fin[9];
              s_nxt.rx_buffer_full = 1'b1; // RQ19
              s_nxt.rx_buffer_full_armed     = 1'b0;
              // break: all-zero frame, registers cleared
              if (rx_fin == 10'h000)
              begin
                s_nxt.rx_data      = 8'h00; // RQ17
                s_nxt.rx_ninth_bit = 1'b0;
              end
            end
          end
        end
      end
    end
  end

  // single state register; reset constants only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r                 <= '0;
      s_r.divisor         <= ucp_pkg::BAUD_RESET;
      s_r.cr1             <= ucp_pkg::CR1_RESET;
      s_r.cr2             <= ucp_pkg::CR2_RESET;
      s_r.tx_buffer_empty <= ucp_pkg::TX_BUFFER_EMPTY_RESET; // RQ5
      s_r.tx_sr           <= 11'h7ff;
      s_r.tx_out          <= 1'b1;
      s_r.rx_s1           <= 1'b1;
      s_r.rx_s2           <= 1'b1;
      s_r.rx_prev         <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

//--- tb/ucp_uart_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ucp_uart_asserts
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        tx_out,
  input wire logic        tx_oe,
  input wire logic        tx_irq,
  input wire logic        rx_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // half a bit at divisor one; shorter means a broken bit counter
  sequence s_low_half;
    (!tx_out) [*8];
  endsequence
  sequence s_high_half;
    tx_out [*8];
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0000_00)
    else $error("upper read lanes not zero");
  a_idle_high: assert property (!tx_oe |-> tx_out)
    else $error("released line not idle high");
  a_zero_min: assert property ($fell(tx_out) |-> s_low_half)
    else $error("low bit too short");
  a_one_min: assert property ($rose(tx_out) |-> s_high_half)
    else $error("high bit too short");
  a_oe_release: assert property ($fell(tx_oe) |-> $past(tx_out) && $past(tx_out, 15))
    else $error("pin released inside a frame");
  a_txirq_clear: assert property ($fell(tx_irq) |-> $rose(s_axi_bvalid))
    else $error("transmit request dropped without a write");
  a_rxirq_clear: assert property ($fell(rx_irq) |->
    s_axi_rvalid || $past(s_axi_rvalid) || s_axi_bvalid)
    else $error("receive request dropped without an access");
endmodule
`default_nettype wire

//--- tb/ucp_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module ucp_far_end
(
  input  wire logic aclk,
  input  wire logic tx_out,
  input  wire logic tx_oe,
  input  wire logic nine,
  output logic      rx_line
);
  logic       line;
  logic [9:0] rxq[$];
  logic [9:0] fr;
  time        t_first = 0;
  // a released pin floats up through the line pull-up
  assign line = tx_oe ? tx_out : 1'b1;
  initial rx_line = 1'b1;
  // mid-bit decoder; waiting for high first makes a break count once
  always
  begin
    @(posedge aclk iff line);
    @(posedge aclk iff !line);
    if (t_first == 0) t_first = $time;
    fr = 10'h000;
    repeat (8) @(posedge aclk);
    for (int i = 0; i <= (nine ? 9 : 8); i++)
    begin
      repeat (16) @(posedge aclk);
      fr[i] = line;
    end
    rxq.push_back({fr[nine ? 9 : 8], nine & fr[8], fr[7:0]});
  end
  // start, data lsb first, chosen stop level, then idle ones
  task automatic send(input logic [8:0] d, input logic n9, input logic stop);
    logic [11:0] f;
    f = n9 ? {1'b1, stop, d, 1'b0} : {2'b11, stop, d[7:0], 1'b0};
    @(posedge aclk);
    for (int i = 0; i < 12; i++)
    begin
      rx_line <= f[i];
      repeat (16) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        nine = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        tx_out, tx_oe, rx_in, tx_irq, rx_irq;
  logic [1:0]  bresp, rresp, br, rr;
  logic [31:0] rdata, rdv;
  logic [7:0]  cr1;
  logic [8:0]  rv;
  logic [9:0]  expq[$];
  logic [7:0]  modes[5] = '{8'h00, 8'h03, 8'h02, 8'h10, 8'h13};
  int          failures = 0;
  int          total_checks = 0;
  int          seed;
  time         t_en;
  always #12.5 aclk = ~aclk;
  ucp_uart_path ucp_uart_path_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_out(tx_out), .tx_oe(tx_oe),
    .rx_in(rx_in), .tx_irq(tx_irq), .rx_irq(rx_irq));
  ucp_far_end ucp_far_end_inst (.aclk(aclk), .tx_out(tx_out), .tx_oe(tx_oe), .nine(nine),
    .rx_line(rx_in));
  // parity takes the top data bit of the character
  function automatic logic [8:0] exp_tx(input logic [7:0] d, input logic [7:0] c);
    logic [8:0] v;
    v = {c[ucp_pkg::CR1_CHAR9_BIT], d};
    if (c[ucp_pkg::CR1_PAR_EN_BIT] && c[ucp_pkg::CR1_CHAR9_BIT]) v[8] = ^d ^ c[0];
    else if (c[ucp_pkg::CR1_PAR_EN_BIT]) v[7] = ^d[6:0] ^ c[0];
    return v;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic aw, w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= {24'h0000_00, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    br = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rdv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic pollst(input int b);
    rdv = 32'h0000_0000;
    while (rdv[b] !== 1'b1) rd(ucp_pkg::ADDR_STAT_ONE);
  endtask
  // the status read with the flag up arms the clearing write
  task automatic txb(input logic [7:0] v);
    pollst(ucp_pkg::SR1_TX_BUFFER_EMPTY_BIT);
    chk(tx_irq, 1'b1);
    wr(ucp_pkg::ADDR_DATA_LOW, v);
    expq.push_back({1'b1, exp_tx(v, cr1)});
  endtask
  // compare every decoded frame in order, then let the stop bit end
  task automatic drain;
    while (ucp_far_end_inst.rxq.size() < expq.size()) @(posedge aclk);
    while (expq.size() > 0) chk(ucp_far_end_inst.rxq.pop_front(), expq.pop_front());
    repeat (32) @(posedge aclk);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge aclk);
    failures++;
    summarize();
  end
  initial
  begin
    seed = 79765;
    cr1 = 8'h00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ucp_pkg::ADDR_STAT_ONE);
    chk(rdv[7], 1'b1);
    rd(ucp_pkg::ADDR_CTRL_TWO);
    chk(rdv, 32'h0000_0000);
    rd(8'h1c);
    chk(rr, ucp_pkg::RESP_SLVERR);
    wr(8'h1c, 8'h55);
    chk(br, ucp_pkg::RESP_SLVERR);
    wr(ucp_pkg::ADDR_BAUD_HIGH, 8'h01);
    rd(ucp_pkg::ADDR_BAUD_HIGH);
    chk(rdv, 32'h0000_0000);
    wr(ucp_pkg::ADDR_BAUD_HIGH, 8'h00);
    wr(ucp_pkg::ADDR_BAUD_LOW, 8'h01);
    chk(br, ucp_pkg::RESP_OKAY);
    t_en = $time;
    wr(ucp_pkg::ADDR_CTRL_TWO, 8'hac);
    chk(tx_oe, 1'b1);
    foreach (modes[m])
    begin
      cr1 = modes[m];
      nine = cr1[4];
      wr(ucp_pkg::ADDR_CTRL_ONE, cr1);
      wr(ucp_pkg::ADDR_DATA_HIGH, 8'h40);
      for (int k = 0; k < 3; k++)
      begin
        txb(k == 0 ? 8'h00 : (k == 1 ? 8'hff : 8'($random(seed))));
        if (m == 0 && k == 0)
        begin
          rd(ucp_pkg::ADDR_STAT_ONE);
          chk(rdv[7], 1'b0);
          chk(tx_irq, 1'b0);
        end
      end
      drain();
      rv = 9'($random(seed));
      ucp_far_end_inst.send(rv, nine, 1'b1);
      pollst(ucp_pkg::SR1_RX_BUFFER_FULL_BIT);
      chk(rx_irq, 1'b1);
      chk(rdv[1], 1'b0);
      rd(ucp_pkg::ADDR_DATA_HIGH);
      if (nine) chk(rdv[7], rv[8]);
      rd(ucp_pkg::ADDR_DATA_LOW);
      chk(rdv, rv[7:0]);
      chk(rx_irq, 1'b0);
    end
    chk((ucp_far_end_inst.t_first - t_en) inside {[4000:4300]}, 1'b1);
    ucp_far_end_inst.send(9'h000, nine, 1'b0);
    pollst(ucp_pkg::SR1_RX_BUFFER_FULL_BIT);
    chk(rdv[1], 1'b1);
    rd(ucp_pkg::ADDR_DATA_LOW);
    chk(rdv, 32'h0000_0000);
    wr(ucp_pkg::ADDR_CTRL_TWO, 8'had);
    while (ucp_far_end_inst.rxq.size() < 1) @(posedge aclk);
    wr(ucp_pkg::ADDR_CTRL_TWO, 8'hac);
    expq.push_back(10'h000);
    txb(8'h3c);
    drain();
    wr(ucp_pkg::ADDR_DATA_LOW, 8'h77);
    repeat (400) @(posedge aclk);
    chk(ucp_far_end_inst.rxq.size(), 0);
    rd(ucp_pkg::ADDR_STAT_ONE);
    chk(rdv[7], 1'b1);
    txb(8'hc3);
    pollst(ucp_pkg::SR1_TX_BUFFER_EMPTY_BIT);
    wr(ucp_pkg::ADDR_CTRL_TWO, 8'h24);
    wr(ucp_pkg::ADDR_CTRL_TWO, 8'hac);
    txb(8'h5a);
    while (ucp_far_end_inst.rxq.size() < 1) @(posedge aclk);
    repeat (200) @(posedge aclk);
    chk(ucp_far_end_inst.rxq.size(), 1);
    wr(ucp_pkg::ADDR_CTRL_TWO, 8'h24);
    chk(tx_oe, 1'b1);
    drain();
    chk(tx_oe, 1'b0);
    summarize();
  end
endmodule
bind ucp_uart_path ucp_uart_asserts ucp_uart_asserts_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .tx_out, .tx_oe, .tx_irq, .rx_irq);
`default_nettype wire
